// ===== rtl/cell_cfg.svh
// offsets, field positions, reset values of the logic cell register map
//
// Functional notes
// - each storage element loads from first, second, third table or direct input
// - each registered output muxes storage element or any control input
// - four routed control inputs map through muxes onto four internal controls
// - logic mode: clock enable, set/reset or h0, direct data or h2, h1
// - memory mode: clock enable, write enable, first data, second data or addr4
// - storage elements work independently while tables do unrelated functions
// - flip-flop is d-type with enable and set or clear; map latch bits are unused
// - first and second tables are ram: level, edge or dual-port edge write
// - memory organised as 16x2, 32x1 or 16x1 by mode
// - set/reset active high; one bit per flop picks set or clear
// - global init sets or clears every flop per its configuration bit
// - combinational outputs carry first or third, second or third result
`ifndef CELL_CFG_SVH
`define CELL_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CELL_CTRL_OFS     12'h000
`define CELL_MAP_OFS      12'h004
`define CELL_TABLE_FG_OFS 12'h008
`define CELL_TABLE_H_OFS  12'h00C
`define CELL_STATUS_OFS   12'h010

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_MEM_BIT      0
`define CTRL_RAM_MODE_LSB 1
`define CTRL_RAM_ORG_LSB  3
`define CTRL_H2_F_BIT     5
`define CTRL_H0_G_BIT     6
`define CTRL_SEL_LSB      8
`define CTRL_RESET        32'h0000_E400

// ----------------------------------------------------------------
// map register fields
// ----------------------------------------------------------------
`define MAP_SRC1_LSB      0
`define MAP_SRC2_LSB      2
`define MAP_BYP1_BIT      4
`define MAP_BYP1_SEL_LSB  5
`define MAP_BYP2_BIT      7
`define MAP_BYP2_SEL_LSB  8
`define MAP_INIT1_BIT     10
`define MAP_INIT2_BIT     11
`define MAP_SREN1_BIT     12
`define MAP_SREN2_BIT     13
`define MAP_LATCH1_BIT    14
`define MAP_LATCH2_BIT    15
`define MAP_XSEL_BIT      16
`define MAP_YSEL_BIT      17
`define MAP_RESET         32'h0000_3000
`define TABLE_H_RESET     8'h00

`endif

// ===== rtl/cell_pkg.sv
// types shared by the logic cell design
package cell_pkg;
    typedef enum logic [1:0] {SRC_F, SRC_G, SRC_H, SRC_DIN} data_src_t;
    typedef enum logic [1:0] {RAM_LEVEL, RAM_EDGE, RAM_DUAL} ram_mode_t;
    typedef enum logic [1:0] {ORG_16X2, ORG_32X1, ORG_16X1} ram_org_t;
endpackage : cell_pkg

// ===== rtl/logic_cell_storage_ctrl.sv
// storage and control path of one configurable logic cell, apb slave
`timescale 1ns/100ps
`include "cell_cfg.svh"
module logic_cell_storage_ctrl
    import cell_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic [3:0]  routed_control_inputs_in,
    input  wire logic [3:0]  f_inputs_in,
    input  wire logic [3:0]  g_inputs_in,
    input  wire logic        global_init_line_in,
    output logic             registered_out_one_out,
    output logic             registered_out_two_out,
    output logic             comb_out_one_out,
    output logic             comb_out_two_out
);
    // ------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------
    logic        rst_meta_reg;
    logic        rst_n;
    logic [12:0] pin_meta_reg;
    logic [12:0] pin_sync_reg;

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end
        else
        begin
            pin_meta_reg <= {global_init_line_in, g_inputs_in, f_inputs_in,
                             routed_control_inputs_in};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    logic [3:0] c_pins;
    logic [3:0] f_addr;
    logic [3:0] g_addr;
    logic       gsr_pin;
    assign c_pins  = pin_sync_reg[3:0];
    assign f_addr  = pin_sync_reg[7:4];
    assign g_addr  = pin_sync_reg[11:8];
    assign gsr_pin = pin_sync_reg[12];

    // ------------------------------------------------------------
    // apb register file
    // ------------------------------------------------------------
    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] map_reg, map_next;
    logic [7:0]  htab_reg, htab_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        pready_reg, pready_next;
    logic        pslverr_reg, pslverr_next;
    logic        init_pulse_reg, init_pulse_next;
    logic        load_fg;
    logic [31:0] status_word;
    logic        setup;
    logic        hit;

    // one wait-free access phase; bad address answers with pslverr
    always_comb
    begin
        ctrl_next       = ctrl_reg;
        map_next        = map_reg;
        htab_next       = htab_reg;
        prdata_next     = '0;
        pslverr_next    = 1'b0;
        init_pulse_next = 1'b0;
        load_fg         = 1'b0;
        setup           = psel_in && !penable_in;
        pready_next     = setup;
        hit             = 1'b1;
        unique case (paddr_in)
            `CELL_CTRL_OFS:     prdata_next = ctrl_reg;
            `CELL_MAP_OFS:      prdata_next = map_reg;
            `CELL_TABLE_FG_OFS: prdata_next = '0;
            `CELL_TABLE_H_OFS:  prdata_next = {24'h00_0000, htab_reg};
            `CELL_STATUS_OFS:   prdata_next = status_word;
            default:            hit = 1'b0;
        endcase
        if (setup && !hit)
            pslverr_next = 1'b1;
        if (psel_in && penable_in && pready_reg && pwrite_in)
        begin
            prdata_next = '0;
            unique case (paddr_in)
                `CELL_CTRL_OFS:
                begin
                    ctrl_next       = pwdata_in;
                    init_pulse_next = 1'b1;
                end
                `CELL_MAP_OFS:
                begin
                    map_next        = pwdata_in;
                    init_pulse_next = 1'b1;
                end
                `CELL_TABLE_FG_OFS: load_fg = 1'b1;
                `CELL_TABLE_H_OFS:  htab_next = pwdata_in[7:0];
                default:            load_fg = 1'b0;
            endcase
        end
        if (!setup)
            prdata_next = (psel_in && penable_in) ? prdata_reg : '0;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg       <= `CTRL_RESET;
            map_reg        <= `MAP_RESET;
            htab_reg       <= `TABLE_H_RESET;
            prdata_reg     <= '0;
            pready_reg     <= 1'b0;
            pslverr_reg    <= 1'b0;
            init_pulse_reg <= 1'b1;
        end
        else
        begin
            ctrl_reg       <= ctrl_next;
            map_reg        <= map_next;
            htab_reg       <= htab_next;
            prdata_reg     <= prdata_next;
            pready_reg     <= pready_next;
            pslverr_reg    <= pslverr_next;
            init_pulse_reg <= init_pulse_next;
        end
    end

    // ------------------------------------------------------------
    // control mapping and mode decode
    // ------------------------------------------------------------
    logic [3:0] ctl;
    logic       mem_mode;
    ram_mode_t  ram_mode;
    ram_org_t   ram_org;

    // any routed input can drive any internal control
    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_ctl_mux
            assign ctl[i] = c_pins[ctrl_reg[`CTRL_SEL_LSB + 2*i +: 2]];
        end
    endgenerate

    assign mem_mode = ctrl_reg[`CTRL_MEM_BIT];
    assign ram_mode = ram_mode_t'(ctrl_reg[`CTRL_RAM_MODE_LSB +: 2]);
    assign ram_org  = ram_org_t'(ctrl_reg[`CTRL_RAM_ORG_LSB +: 2]);

    // ------------------------------------------------------------
    // table memory write decode
    // ------------------------------------------------------------
    logic we_prev_reg, we_prev_next;
    logic wr_req;
    logic wr_f;
    logic wr_g;
    logic f_raw;
    logic g_raw;
    logic [3:0] rd_g_addr;

    always_comb
    begin
        we_prev_next = ctl[1];
        if (ram_mode == RAM_LEVEL)
            wr_req = ctl[1];
        else
            wr_req = ctl[1] && !we_prev_reg;
        wr_req = wr_req && mem_mode && ctl[0];
        wr_f   = wr_req;
        wr_g   = 1'b0;
        rd_g_addr = g_addr;
        if (ram_mode == RAM_DUAL)
            wr_g = wr_req;
        else
        begin
            unique case (ram_org)
                ORG_16X2: wr_g = wr_req;
                ORG_32X1:
                begin
                    wr_f      = wr_req && !ctl[3];
                    wr_g      = wr_req && ctl[3];
                    rd_g_addr = mem_mode ? f_addr : g_addr;
                end
                default:  wr_g = 1'b0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            we_prev_reg <= 1'b0;
        else
            we_prev_reg <= we_prev_next;
    end

    lut_ram #(
        .ADDR_W (4)
    ) u_lut_ram (
        .clk_in       (sys_clk_in),
        .rstn_in      (rst_n),
        .load_in      (load_fg),
        .load_data_in (pwdata_in),
        .wr_f_in      (wr_f),
        .wr_g_in      (wr_g),
        .wr_addr_in   (f_addr),
        .wr_f_data_in (ctl[2]),
        .wr_g_data_in ((ram_org == ORG_16X2 && ram_mode != RAM_DUAL)
                       ? ctl[3] : ctl[2]),
        .rd_f_addr_in (f_addr),
        .rd_g_addr_in (rd_g_addr),
        .f_out        (f_raw),
        .g_out        (g_raw)
    );

    // ------------------------------------------------------------
    // storage elements and output muxes
    // ------------------------------------------------------------
    logic [1:0] q_reg, q_next;
    logic [1:0] xq_reg, xq_next;
    logic       xo_reg, xo_next;
    logic       yo_reg, yo_next;
    logic       f_val;
    logic       h_val;
    logic [2:0] h_idx;
    logic       global_init_line;
    logic       sr;
    logic [1:0] d_sel;

    always_comb
    begin
        f_val = (mem_mode && ram_org == ORG_32X1 && ram_mode != RAM_DUAL
                 && ctl[3]) ? g_raw : f_raw;
        h_idx[0] = ctrl_reg[`CTRL_H0_G_BIT] ? g_raw : ctl[1];
        h_idx[1] = ctl[3];
        h_idx[2] = ctrl_reg[`CTRL_H2_F_BIT] ? f_val : ctl[2];
        h_val    = htab_reg[h_idx];
        global_init_line      = gsr_pin || init_pulse_reg;
        sr       = ctl[1] && !mem_mode;
        q_next   = q_reg;
        for (int i = 0; i < 2; i++)
        begin
            unique case (data_src_t'(map_reg[`MAP_SRC1_LSB + 2*i +: 2]))
                SRC_F:   d_sel[i] = f_val;
                SRC_G:   d_sel[i] = g_raw;
                SRC_H:   d_sel[i] = h_val;
                SRC_DIN: d_sel[i] = ctl[2];
            endcase
            if (global_init_line)
                q_next[i] = map_reg[`MAP_INIT1_BIT + i];
            else if (sr && map_reg[`MAP_SREN1_BIT + i])
                q_next[i] = map_reg[`MAP_INIT1_BIT + i];
            else if (ctl[0])
                q_next[i] = d_sel[i];
            else
                q_next[i] = q_reg[i];
        end
        xq_next[0] = map_reg[`MAP_BYP1_BIT]
                     ? ctl[map_reg[`MAP_BYP1_SEL_LSB +: 2]] : q_reg[0];
        xq_next[1] = map_reg[`MAP_BYP2_BIT]
                     ? ctl[map_reg[`MAP_BYP2_SEL_LSB +: 2]] : q_reg[1];
        xo_next = map_reg[`MAP_XSEL_BIT] ? h_val : f_val;
        yo_next = map_reg[`MAP_YSEL_BIT] ? h_val : g_raw;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q_reg  <= 2'h0;
            xq_reg <= 2'h0;
            xo_reg <= 1'b0;
            yo_reg <= 1'b0;
        end
        else
        begin
            q_reg  <= q_next;
            xq_reg <= xq_next;
            xo_reg <= xo_next;
            yo_reg <= yo_next;
        end
    end

    // status view of the cell
    assign status_word = {23'h00_0000, mem_mode, ctl, yo_reg, xo_reg, q_reg};

    assign prdata_out             = prdata_reg;
    assign pready_out             = pready_reg;
    assign pslverr_out            = pslverr_reg;
    assign registered_out_one_out = xq_reg[0];
    assign registered_out_two_out = xq_reg[1];
    assign comb_out_one_out       = xo_reg;
    assign comb_out_two_out       = yo_reg;
endmodule : logic_cell_storage_ctrl

// ===== rtl/lut_ram.sv
// two 16-bit lookup tables usable as write-able memory
`timescale 1ns/100ps
module lut_ram #(
    parameter int ADDR_W = 4
) (
    input  wire logic              clk_in,
    input  wire logic              rstn_in,
    input  wire logic              load_in,
    input  wire logic [31:0]       load_data_in,
    input  wire logic              wr_f_in,
    input  wire logic              wr_g_in,
    input  wire logic [ADDR_W-1:0] wr_addr_in,
    input  wire logic              wr_f_data_in,
    input  wire logic              wr_g_data_in,
    input  wire logic [ADDR_W-1:0] rd_f_addr_in,
    input  wire logic [ADDR_W-1:0] rd_g_addr_in,
    output logic                   f_out,
    output logic                   g_out
);
    localparam int DEPTH = 1 << ADDR_W;

    logic [DEPTH-1:0] f_mem_reg;
    logic [DEPTH-1:0] f_mem_next;
    logic [DEPTH-1:0] g_mem_reg;
    logic [DEPTH-1:0] g_mem_next;
    logic             f_rd_reg;
    logic             f_rd_next;
    logic             g_rd_reg;
    logic             g_rd_next;

    // ------------------------------------------------------------
    // table load, user write, registered read
    // ------------------------------------------------------------
    always_comb
    begin
        f_mem_next = f_mem_reg;
        g_mem_next = g_mem_reg;
        if (load_in)
        begin
            f_mem_next = load_data_in[DEPTH-1:0];
            g_mem_next = load_data_in[16 +: DEPTH];
        end
        else
        begin
            if (wr_f_in)
                f_mem_next[wr_addr_in] = wr_f_data_in;
            if (wr_g_in)
                g_mem_next[wr_addr_in] = wr_g_data_in;
        end
        f_rd_next = f_mem_reg[rd_f_addr_in];
        g_rd_next = g_mem_reg[rd_g_addr_in];
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            f_mem_reg <= '0;
            g_mem_reg <= '0;
            f_rd_reg  <= 1'b0;
            g_rd_reg  <= 1'b0;
        end
        else
        begin
            f_mem_reg <= f_mem_next;
            g_mem_reg <= g_mem_next;
            f_rd_reg  <= f_rd_next;
            g_rd_reg  <= g_rd_next;
        end
    end

    assign f_out = f_rd_reg;
    assign g_out = g_rd_reg;
endmodule : lut_ram

// ===== tb/logic_cell_storage_ctrl_checker.sv
// port-level assertions for the logic cell storage and control path
`timescale 1ns/100ps
module logic_cell_storage_ctrl_checker (
    input  wire logic        sys_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [31:0] prdata_out,
    input  wire logic        pready_out,
    input  wire logic        pslverr_out,
    input  wire logic        global_init_line_in,
    input  wire logic        registered_out_one_out,
    input  wire logic        registered_out_two_out,
    input  wire logic        comb_out_one_out,
    input  wire logic        comb_out_two_out
);
    logic [31:0] map_reg;
    logic [31:0] map_next;
    logic [2:0]  hold_reg;
    logic [2:0]  hold_next;
    logic        mapped;
    logic        map_wr;

    // --------------------
    // helper state
    // --------------------
    // map shadow and age of a steady global init level
    always_comb
    begin
        mapped    = paddr_in[1:0] == 2'h0 && paddr_in <= 12'h010;
        map_wr    = pready_out && pwrite_in && paddr_in == 12'h004;
        map_next  = map_wr ? pwdata_in : map_reg;
        hold_next = hold_reg + {2'h0, hold_reg != 3'h7};
        if (!global_init_line_in || map_wr)
            hold_next = 3'h0;
    end
    // shadow registers
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            map_reg  <= 32'h0000_3000;
            hold_reg <= 3'h0;
        end
        else
        begin
            map_reg  <= map_next;
            hold_reg <= hold_next;
        end
    end

    // --------------------
    // assertions
    // --------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    a_ready_after_setup:
    assert property (psel_in && !penable_in |=> pready_out)
        else $error("no ready after setup");
    a_ready_in_access:
    assert property (pready_out |-> psel_in && penable_in
        && $past(psel_in) && !$past(penable_in))
        else $error("ready outside an access");
    a_ready_single:
    assert property (pready_out |=> !pready_out)
        else $error("ready held two cycles");
    a_err_unmapped:
    assert property (pready_out && !mapped |->
        pslverr_out && prdata_out == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_err_mapped:
    assert property (pready_out && mapped |-> !pslverr_out)
        else $error("mapped access refused");
    a_table_reads_zero:
    assert property (pready_out && !pwrite_in && paddr_in == 12'h008
        |-> prdata_out == 32'h0000_0000)
        else $error("table read not zero");
    a_init_status:
    assert property (pready_out && !pwrite_in && paddr_in == 12'h010
        && hold_reg == 3'h7 |-> prdata_out[1:0] == map_reg[11:10])
        else $error("global init not seen in flops");
    a_reset_quiet:
    assert property ($rose(rstn_in) |-> !registered_out_one_out
        && !registered_out_two_out && !comb_out_one_out && !comb_out_two_out)
        else $error("outputs not clear at reset");
endmodule : logic_cell_storage_ctrl_checker

bind logic_cell_storage_ctrl logic_cell_storage_ctrl_checker
    logic_cell_storage_ctrl_checker_i (.sys_clk_in, .rstn_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
    .pready_out, .pslverr_out, .global_init_line_in,
    .registered_out_one_out, .registered_out_two_out, .comb_out_one_out,
    .comb_out_two_out);

// ===== tb/logic_cell_storage_ctrl_tb_top.sv
// self-checking bench for the logic cell storage and control path
`timescale 1ns/100ps
`include "cell_cfg.svh"
module logic_cell_storage_ctrl_tb_top
    import cell_pkg::*;
;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        slow = 1'b0;
    logic        chk_now = 1'b0;
    logic [12:0] req = 13'h0000;
    logic [12:0] pins;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  outs;
    logic [31:0] ctrl = `CTRL_RESET;
    logic [31:0] map = `MAP_RESET;
    logic [31:0] fg = 32'h0000_0000;
    logic [31:0] ht = 32'h0000_0000;
    logic [1:0]  q = 2'h0;
    logic [32:0] rq[$];
    logic [3:0]  oq[$];
    logic [31:0] a;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          seed = 65328;

    // --------------------
    // clock, partner, design
    // --------------------
    always #5 clk = ~clk;
    routing_model routing_model_i (.clk_in(clk), .slow_in(slow),
        .req_in(req), .pins_out(pins));
    logic_cell_storage_ctrl logic_cell_storage_ctrl_i (.sys_clk_in(clk),
        .rstn_in(rstn), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .routed_control_inputs_in(pins[3:0]), .f_inputs_in(pins[7:4]),
        .g_inputs_in(pins[11:8]), .global_init_line_in(pins[12]),
        .registered_out_one_out(outs[3]), .registered_out_two_out(outs[2]),
        .comb_out_one_out(outs[1]), .comb_out_two_out(outs[0]));

    // --------------------
    // reporting
    // --------------------
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    task automatic tally(input string n, input logic [32:0] e, s);
        checks_done++;
        if (s !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : tally
    task automatic cmp_bus(input logic [32:0] e, s);
        tally("read data", e, s);
    endtask : cmp_bus
    task automatic cmp_cell(input logic [3:0] e, s);
        tally("cell outputs", {29'h0, e}, {29'h0, s});
    endtask : cmp_cell

    // oldest note is compared whenever a result shows
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            cmp_bus(rq.pop_front(), {pslverr, prdata});
        if (chk_now)
            cmp_cell(oq.pop_front(), outs);
    end

    // --------------------
    // drivers
    // --------------------
    // one apb transfer, read data expectation queued first
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] d, input logic [32:0] e);
        int n;
        n = 0;
        if (!w)
            rq.push_back(e);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 16)
        begin
            error_cnt++;
            give_verdict();
        end
        if (w && ad == `CELL_CTRL_OFS)
            ctrl = d;
        if (w && ad == `CELL_MAP_OFS)
            map = d;
        if (w && ad == `CELL_TABLE_FG_OFS)
            fg = d;
        if (w && ad == `CELL_TABLE_H_OFS)
            ht = d;
        if (w && ad < `CELL_TABLE_FG_OFS)
            q = map[11:10];
        @(posedge clk);
    endtask : apb
    // routed pins change, then settle
    task automatic drive(input logic [12:0] v);
        req <= v;
        repeat (10) @(posedge clk);
    endtask : drive
    // cell outputs and status worked out from the pins
    task automatic check_cell;
        logic [3:0] c;
        logic [3:0] s;
        logic [1:0] o;
        logic       f;
        logic       g;
        logic       h;
        logic       m32;
        for (int i = 0; i < 4; i++)
            c[i] = req[ctrl[8+2*i +: 2]];
        // 32x1 memory view: second table read at first address
        m32 = ctrl[0] && ctrl[4:3] == 2'h1 && ctrl[2:1] != 2'h2;
        g = fg[16 + (m32 ? req[7:4] : req[11:8])];
        f = (m32 && c[3]) ? g : fg[req[7:4]];
        h = ht[{ctrl[5] ? f : c[2], c[3], ctrl[6] ? g : c[1]}];
        s = {c[2], h, g, f};
        for (int k = 0; k < 2; k++)
        begin
            if (req[12] || (map[12+k] && c[1] && !ctrl[0]))
                q[k] = map[10+k];
            else if (c[0])
                q[k] = s[map[2*k +: 2]];
            o[k] = map[4+3*k] ? c[map[5+3*k +: 2]] : q[k];
        end
        f = map[16] ? h : f;
        g = map[17] ? h : g;
        oq.push_back({o[0], o[1], f, g});
        chk_now <= 1'b1;
        @(posedge clk);
        chk_now <= 1'b0;
        apb(1'b0, `CELL_STATUS_OFS, 0, {24'h0, ctrl[0], c, g, f, q});
    endtask : check_cell

    // --------------------
    // main sequence
    // --------------------
    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        apb(1'b0, `CELL_CTRL_OFS, 0, {1'b0, `CTRL_RESET});
        apb(1'b0, `CELL_MAP_OFS, 0, {1'b0, `MAP_RESET});
        apb(1'b0, `CELL_TABLE_H_OFS, 0, 33'h0);
        apb(1'b1, 12'h020, 32'hFFFF_FFFF, 0);
        apb(1'b0, 12'h014, 0, {1'b1, 32'h0000_0000});
        apb(1'b0, `CELL_TABLE_FG_OFS, 0, 33'h0);
        check_cell();
        $display("test reset and map done");
        for (int it = 0; it < 16; it++)
        begin
            drive(13'h0000);
            slow <= it[0];
            apb(1'b1, `CELL_TABLE_FG_OFS, $random(seed), 0);
            apb(1'b1, `CELL_TABLE_H_OFS, $random(seed) & 32'h0000_00FF, 0);
            apb(1'b1, `CELL_CTRL_OFS, $random(seed) & 32'h0000_FF60, 0);
            apb(1'b1, `CELL_MAP_OFS, $random(seed) & 32'h0003_FFFF, 0);
            apb(1'b0, `CELL_MAP_OFS, 0, {1'b0, map});
            drive({it[1:0] == 2'h0, 12'($random(seed))});
            check_cell();
        end
        $display("test logic mode done");
        for (int m = 0; m < 3; m++)
        begin
            a = $random(seed);
            drive(13'h0000);
            apb(1'b1, `CELL_CTRL_OFS, 32'h0000_E401 | (m << 1) | (m << 3), 0);
            apb(1'b1, `CELL_MAP_OFS, 32'h0000_0004, 0);
            drive({1'b0, a[3:0], a[3:0], a[5:4], 2'h1});
            drive({1'b0, a[3:0], a[3:0], a[5:4], 2'h3});
            if (m != 1 || !a[5])
                fg[a[3:0]] = a[4];
            if (m == 0)
                fg[16 + a[3:0]] = a[5];
            if (m == 2 || (m == 1 && a[5]))
                fg[16 + a[3:0]] = a[4];
            check_cell();
            drive({1'b0, a[3:0], a[3:0], ~a[5:4], 2'h0});
            drive({1'b0, a[3:0], a[3:0], ~a[5:4], 2'h2});
            check_cell();
        end
        $display("test memory mode done");
        give_verdict();
    end
endmodule : logic_cell_storage_ctrl_tb_top

// ===== tb/routing_model.sv
// routing interconnect model driving the cell's routed pins
`timescale 1ns/100ps
module routing_model (
    input  wire logic        clk_in,
    input  wire logic        slow_in,
    input  wire logic [12:0] req_in,
    output logic      [12:0] pins_out
);
    logic [12:0] stage_reg;
    logic [12:0] stage_next;

    // a slow route lags one cycle behind a prompt one
    always_comb
    begin
        stage_next = req_in;
    end
    always_ff @(posedge clk_in)
    begin
        stage_reg <= stage_next;
    end
    assign pins_out = slow_in ? stage_reg : req_in;
endmodule : routing_model
